// >>> src/wdt_pkg.sv
// constants shared by the watchdog / stabilization timer and its prescaler
// assumes an 8-bit register file with byte addresses decoded by the block itself
package wdt_pkg;

	// register addresses
	localparam logic [7:0] ADDR_CONTROL = 8'hDC;
	localparam logic [7:0] ADDR_COUNT   = 8'hDD;

	// control register layout
	localparam int         SIG_MSB         = 7;
	localparam int         SIG_LSB         = 4;
	localparam int         SEL_MSB         = 3;
	localparam int         SEL_LSB         = 2;
	localparam int         BIT_COUNT_CLEAR = 1;
	localparam int         BIT_DIV_CLEAR   = 0;
	localparam logic [3:0] SIG_DISABLE     = 4'hA;
	localparam logic [3:0] SIG_RESET       = 4'h0;
	localparam logic [1:0] SEL_RESET       = 2'h0;
	localparam logic [1:0] CLEAR_BITS_READ = 2'h0;

	// prescaler ratio select codes
	localparam logic [1:0] SEL_DIV_4096 = 2'h0;
	localparam logic [1:0] SEL_DIV_1024 = 2'h1;
	localparam logic [1:0] SEL_DIV_128  = 2'h2;
	localparam logic [1:0] SEL_DIV_16   = 2'h3;

	// divider: 4096 = 2**12, so a 12-bit free-running chain serves every ratio
	localparam int          DIV_WIDTH    = 12;
	localparam logic [11:0] MASK_4096    = 12'hFFF;
	localparam logic [11:0] MASK_1024    = 12'h3FF;
	localparam logic [11:0] MASK_128     = 12'h07F;
	localparam logic [11:0] MASK_16      = 12'h00F;
	localparam logic [11:0] DIV_ZERO     = 12'h000;
	localparam logic [11:0] DIV_ONE      = 12'h001;

	// counter constants
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	localparam logic [7:0] COUNT_ONE  = 8'h01;
	localparam logic [7:0] COUNT_FULL = 8'hFF;
	localparam logic [3:0] NIBBLE_FULL = 4'hF;
	localparam logic [7:0] READ_ZERO  = 8'h00;

	// one-hot operating states
	typedef enum logic [2:0] {
		ST_STABILIZE = 3'b001,
		ST_RUN       = 3'b010,
		ST_STOP      = 3'b100
	} timer_state_t;

endpackage

// >>> src/wdt_prescaler.sv
// prescaler chain for the watchdog timer unit: one registered tick per selected ratio
// assumes clk is the system clock and that clear and run come from the same domain
module wdt_prescaler
	import wdt_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic       clear,
	input  wire logic [1:0] sel,
	output logic            tick
);

	logic [DIV_WIDTH-1:0] div;
	logic [DIV_WIDTH-1:0] next_div;
	logic [DIV_WIDTH-1:0] mask;
	logic                 next_tick;

	always_comb begin
		case (sel)
			SEL_DIV_4096: mask = MASK_4096;
			SEL_DIV_1024: mask = MASK_1024;
			SEL_DIV_128:  mask = MASK_128;
			SEL_DIV_16:   mask = MASK_16;
			default:      mask = MASK_4096;
		endcase
	end

	always_comb begin
		next_div  = div;
		next_tick = 1'b0;
		if (clear) begin
			next_div = DIV_ZERO;
		end else if (run) begin
			next_div  = div + DIV_ONE;
			// a clear or a stop suppresses the tick so no stray count follows
			next_tick = ((div & mask) == mask);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div  <= DIV_ZERO;
			tick <= 1'b0;
		end else begin
			div  <= next_div;
			tick <= next_tick;
		end
	end

endmodule // wdt_prescaler

// >>> src/basic_watchdog_stabilization_timer.sv
// watchdog timer unit: eight-bit count of prescaled clock, watchdog reset, stop wake-up timing
// assumes a register port synchronous to clk and that chip_reset_request is fed back to sys_rst
//
// Notes on behaviour
// - prescaler divides system clock by 4096/1024/128/16
// - eight-bit read-only up-counter at own address
// - reset loads control zero: watchdog on, 4096
// - only signature 1010 disables watchdog reset
// - control bit 1 write clears counter
// - control bit 0 write clears prescaler dividers
// - enabled watchdog resets chip on bit 7 overflow
// - stop ended by reset or interrupt restarts oscillator
// - reset wake uses 4096, interrupt keeps selection
// - bit 3 carry ends stabilization, enables cpu clock
module basic_watchdog_stabilization_timer
	import wdt_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       stop_request,
	input  wire logic       wake_interrupt,
	output logic            osc_enable,
	output logic            cpu_clock_enable,
	output logic            watchdog_enabled,
	output logic            stabilization_done,
	output logic            counter_overflow_pulse,
	output logic            chip_reset_request
);

	// control register fields
	logic [3:0]   ctrl_sig;
	logic [3:0]   next_ctrl_sig;
	logic [1:0]   ctrl_sel;
	logic [1:0]   next_ctrl_sel;

	// counter and operating state
	logic [7:0]   count;
	logic [7:0]   next_count;
	timer_state_t state;
	timer_state_t next_state;

	// registered event outputs and read data
	logic         next_stabilization_done;
	logic         next_counter_overflow_pulse;
	logic         next_chip_reset_request;
	logic [7:0]   next_reg_rdata;
	logic         next_osc_enable;
	logic         next_cpu_clock_enable;
	logic         next_watchdog_enabled;

	// decoded strobes
	logic         wr_ctrl;
	logic         count_clear;
	logic         div_clear;
	logic         wake;
	logic         prescale_run;
	logic         tick;
	logic         nibble_carry;
	logic         count_wrap;
	logic         wd_on;

	// wake cause and the rate actually fed to the prescaler
	logic         reset_wake;
	logic         next_reset_wake;
	logic [1:0]   count_sel;

	assign wr_ctrl      = reg_wr && (reg_addr == ADDR_CONTROL);
	assign count_clear  = wr_ctrl && reg_wdata[BIT_COUNT_CLEAR];
	assign div_clear    = wr_ctrl && reg_wdata[BIT_DIV_CLEAR];
	assign wake         = (state == ST_STOP) && wake_interrupt;
	assign prescale_run = (state != ST_STOP);
	assign wd_on        = (ctrl_sig != SIG_DISABLE);
	assign count_sel    = reset_wake ? SEL_DIV_4096 : ctrl_sel;

	// carry out of bit 3 and out of bit 7 on the counting edge
	assign nibble_carry = tick && (count[3:0] == NIBBLE_FULL);
	assign count_wrap   = tick && (count == COUNT_FULL);

	// the prescaler is restarted on wake so the interval starts from a clean edge
	wdt_prescaler u_prescaler (
		.clk     (clk),
		.sys_rst (sys_rst),
		.run     (prescale_run),
		.clear   (div_clear || wake),
		.sel     (count_sel),
		.tick    (tick)
	);

	// control register: the two clear bits are strobes and are never stored
	always_comb begin
		next_ctrl_sig = ctrl_sig;
		next_ctrl_sel = ctrl_sel;
		if (wr_ctrl) begin
			next_ctrl_sig = reg_wdata[SIG_MSB:SIG_LSB];
			// an interrupt wake keeps this selection, only a reset reloads 4096
			next_ctrl_sel = reg_wdata[SEL_MSB:SEL_LSB];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_sig <= SIG_RESET;
			ctrl_sel <= SEL_RESET;
		end else begin
			ctrl_sig <= next_ctrl_sig;
			ctrl_sel <= next_ctrl_sel;
		end
	end

	// counter: a software clear wins over a tick landing in the same cycle
	always_comb begin
		next_count = count;
		if (count_clear || wake) begin
			next_count = COUNT_ZERO;
		end else if (tick) begin
			// 8'hFF + 1 wraps to zero; with the watchdog off only the overflow pulse follows
			next_count = count + COUNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count <= COUNT_ZERO;
		end else begin
			count <= next_count;
		end
	end

	// wake cause: a reset pins the rate to 4096 until its interval ends,
	// so a control write made meanwhile cannot shorten oscillator settling
	always_comb begin
		next_reset_wake = reset_wake;
		if ((state == ST_STABILIZE) && nibble_carry) begin
			next_reset_wake = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reset_wake <= 1'b1;
		end else begin
			reset_wake <= next_reset_wake;
		end
	end

	// operating state: a reset always starts a stabilization interval
	always_comb begin
		next_state              = state;
		next_stabilization_done = 1'b0;
		case (state)
			ST_STABILIZE: begin
				if (nibble_carry) begin
					next_state              = ST_RUN;
					next_stabilization_done = 1'b1;
				end
			end
			ST_RUN: begin
				if (stop_request) begin
					next_state = ST_STOP;
				end
			end
			ST_STOP: begin
				if (wake_interrupt) begin
					next_state = ST_STABILIZE;
				end
			end
			default: begin
				next_state = ST_STABILIZE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state              <= ST_STABILIZE;
			stabilization_done <= 1'b0;
		end else begin
			state              <= next_state;
			stabilization_done <= next_stabilization_done;
		end
	end

	// overflow events: only raised once the processor clock runs
	always_comb begin
		next_counter_overflow_pulse = 1'b0;
		next_chip_reset_request     = 1'b0;
		if (count_wrap && (state == ST_RUN) && !count_clear) begin
			next_counter_overflow_pulse = 1'b1;
			next_chip_reset_request     = wd_on;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			counter_overflow_pulse <= 1'b0;
			chip_reset_request     <= 1'b0;
		end else begin
			counter_overflow_pulse <= next_counter_overflow_pulse;
			chip_reset_request     <= next_chip_reset_request;
		end
	end

	// read port: data held until the next read; unmapped addresses read zero
	always_comb begin
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_CONTROL: next_reg_rdata = {ctrl_sig, ctrl_sel, CLEAR_BITS_READ};
				ADDR_COUNT:   next_reg_rdata = count;
				default:      next_reg_rdata = READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= READ_ZERO;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// status levels registered from the next values so they switch with the state
	always_comb begin
		next_osc_enable       = (next_state != ST_STOP);
		next_cpu_clock_enable = (next_state == ST_RUN);
		next_watchdog_enabled = (next_ctrl_sig != SIG_DISABLE);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			osc_enable       <= 1'b1;
			cpu_clock_enable <= 1'b0;
			watchdog_enabled <= 1'b1;
		end else begin
			osc_enable       <= next_osc_enable;
			cpu_clock_enable <= next_cpu_clock_enable;
			watchdog_enabled <= next_watchdog_enabled;
		end
	end

endmodule // basic_watchdog_stabilization_timer

// >>> bench/wdt_sva.sv
// checker for the watchdog timer unit ports
// assumes it is bound to the top module
module wdt_sva
	import wdt_pkg::*;
(
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       stop_request,
	input wire logic       wake_interrupt,
	input wire logic       osc_enable,
	input wire logic       cpu_clock_enable,
	input wire logic       watchdog_enabled,
	input wire logic       stabilization_done,
	input wire logic       counter_overflow_pulse,
	input wire logic       chip_reset_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire wc = reg_wr && reg_addr == ADDR_CONTROL;
	AST_RST: assert property (disable iff (1'b0) sys_rst
		|=> watchdog_enabled && osc_enable && !cpu_clock_enable) else $error("reset state wrong");
	AST_SIG: assert property (wc
		|=> watchdog_enabled == ($past(reg_wdata[7:4]) != SIG_DISABLE))
		else $error("watchdog enable wrong");
	AST_CLR: assert property (wc && reg_wdata[1] ##1 reg_rd && reg_addr == ADDR_COUNT
		|=> reg_rdata == COUNT_ZERO) else $error("count not cleared");
	AST_UNMAP: assert property (reg_rd && reg_addr != ADDR_CONTROL && reg_addr != ADDR_COUNT
		|=> reg_rdata == READ_ZERO) else $error("unmapped read not zero");
	AST_CREAD: assert property (reg_rd && reg_addr == ADDR_CONTROL
		|=> reg_rdata[1:0] == 2'h0) else $error("strobe bits read back");
	AST_WDRST: assert property (chip_reset_request
		|-> counter_overflow_pulse && $past(cpu_clock_enable)) else $error("reset without overflow");
	AST_WDEN: assert property (counter_overflow_pulse
		|-> chip_reset_request == $past(watchdog_enabled)) else $error("reset not set by enable");
	AST_NOWD: assert property (counter_overflow_pulse && !watchdog_enabled
		&& !$past(watchdog_enabled) |-> !chip_reset_request) else $error("reset while disabled");
	AST_DONE: assert property ($rose(cpu_clock_enable)
		|-> stabilization_done ##1 !stabilization_done) else $error("done pulse wrong");
	AST_STOP: assert property (cpu_clock_enable && stop_request |=> !osc_enable)
		else $error("stop not entered");
	AST_WAKE: assert property (!osc_enable && wake_interrupt
		|=> osc_enable && !cpu_clock_enable) else $error("wake failed");
	cover property (chip_reset_request);
	cover property (stabilization_done);
	cover property (!osc_enable && wake_interrupt);
	cover property (counter_overflow_pulse && !chip_reset_request);
endmodule // wdt_sva

// >>> bench/tb_top.sv
// self-checking bench for the watchdog timer unit
// assumes the package and design compile first; chip reset is watched, not fed back
module tb_top
	import wdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
	logic       stop_request = 0, wake_interrupt = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_v;
	logic       osc_enable, cpu_clock_enable, watchdog_enabled;
	logic       stabilization_done, counter_overflow_pulse, chip_reset_request;
	logic [3:0] sig;
	int         miscompares = 0, samples_checked = 0, seed = 32'h94C8, n;
	always #20 clk = ~clk;
	basic_watchdog_stabilization_timer dut_u (
		.clk                    (clk),
		.sys_rst                (sys_rst),
		.reg_addr               (reg_addr),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_wdata              (reg_wdata),
		.reg_rdata              (reg_rdata),
		.stop_request           (stop_request),
		.wake_interrupt         (wake_interrupt),
		.osc_enable             (osc_enable),
		.cpu_clock_enable       (cpu_clock_enable),
		.watchdog_enabled       (watchdog_enabled),
		.stabilization_done     (stabilization_done),
		.counter_overflow_pulse (counter_overflow_pulse),
		.chip_reset_request     (chip_reset_request)
	);
	function int ratio(logic [1:0] s);
		return s == 2'h0 ? 4096 : s == 2'h1 ? 1024 : s == 2'h2 ? 128 : 16;
	endfunction
	task step(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task chk(logic [7:0] got, logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		step(1);
		reg_wr = 0;
	endtask
	task rd(logic [7:0] a);
		reg_addr = a;
		reg_rd = 1;
		step(1);
		reg_rd = 0;
		rd_v = reg_rdata;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// 0 done, 1 overflow, 2 chip reset; pulses are seen one step after their edge
	function logic flag(int which);
		case (which)
			0: return stabilization_done;
			1: return counter_overflow_pulse;
			default: return chip_reset_request;
		endcase
	endfunction
	task wait_for(input int which, input int lim);
		n = 0;
		while (flag(which) !== 1'b1 && n < lim) begin
			step(1);
			n++;
		end
		if (flag(which) !== 1'b1) begin
			miscompares++;
			$display("unexpected at %0t: timeout", $time);
			finish_test;
		end
	endtask
	// sticky record of any chip reset request, the pulse lasts one cycle only
	logic rst_seen = 1'b0;
	always @(posedge clk) begin
		if (chip_reset_request === 1'b1) begin
			rst_seen <= 1'b1;
		end
	end
	initial begin
		step(8);
		sys_rst = 0;
		rd(ADDR_CONTROL);
		chk(rd_v, 8'h00);
		chk({7'h00, watchdog_enabled}, 8'h01);
		// a faster rate written during the reset interval must not shorten it
		wr(ADDR_CONTROL, 8'h0C);
		rd(8'h3C);
		chk(rd_v, 8'h00);
		step(1);
		rd(ADDR_CONTROL);
		chk(rd_v, 8'h0C);
		wait_for(0, 70000);
		chk({7'h00, n > 65000}, 8'h01);
		chk({7'h00, cpu_clock_enable}, 8'h01);
		rd(ADDR_COUNT);
		chk(rd_v, 8'h10);
		wr(ADDR_COUNT, 8'h55);
		rd(ADDR_COUNT);
		chk(rd_v, 8'h10);
		wr(ADDR_CONTROL, 8'hAF);
		rd(ADDR_CONTROL);
		chk(rd_v, 8'hAC);
		wr(ADDR_CONTROL, 8'hAE);
		rd(ADDR_COUNT);
		chk(rd_v, 8'h00);
		wait_for(1, 4200);
		chk({7'h00, n > 4080 && n < 4100}, 8'h01);
		chk({7'h00, chip_reset_request}, 8'h00);
		// divider cleared with the count, so the read lands mid-step
		for (int s = 0; s < 4; s++) begin
			sig = 4'($random(seed));
			wr(ADDR_CONTROL, {sig, s[1:0], 2'h3});
			chk({7'h00, watchdog_enabled}, {7'h00, sig != SIG_DISABLE});
			step(ratio(s[1:0]) * 5 / 2);
			rd(ADDR_COUNT);
			chk(rd_v, 8'h02);
		end
		wr(ADDR_CONTROL, 8'hAC);
		stop_request = 1;
		step(1);
		stop_request = 0;
		chk({7'h00, osc_enable}, 8'h00);
		chk({7'h00, cpu_clock_enable}, 8'h00);
		step(5);
		wake_interrupt = 1;
		step(1);
		wake_interrupt = 0;
		chk({7'h00, osc_enable}, 8'h01);
		wait_for(0, 300);
		chk({7'h00, n > 240}, 8'h01);
		rd(ADDR_CONTROL);
		chk(rd_v, 8'hAC);
		// watchdog armed, software keeps clearing well inside the overflow period
		sig = 4'($random(seed));
		wr(ADDR_CONTROL, {sig == SIG_DISABLE ? 4'h5 : sig, 4'hF});
		repeat (2) begin
			step(2500);
			wr(ADDR_CONTROL, {sig == SIG_DISABLE ? 4'h5 : sig, 4'hF});
		end
		chk({7'h00, rst_seen}, 8'h00);
		wait_for(2, 4200);
		chk({7'h00, n > 4080}, 8'h01);
		finish_test;
	end
endmodule // tb_top
bind basic_watchdog_stabilization_timer wdt_sva chk_u (.*);
